//--- logic/alarm_flag_consts.svh
// Constants for the diagnostic alarm flag bank
`ifndef ALARM_FLAG_CONSTS_SVH
`define ALARM_FLAG_CONSTS_SVH

`define DIAG_DEV_ADDR 7'h51
`define ALARM_PRIMARY_OFFSET 8'h70
`define ALARM_RX_POWER_OFFSET 8'h71
`define ALARM_RESET_VALUE 8'h00
`define ALARM_RX_RESERVED_MASK 8'h3F
`define RX_OVERLOAD_BIT 7
`define RX_LOSS_BIT 6
`define TEMP_OVER_BIT 7
`define TEMP_UNDER_BIT 6
`define SUPPLY_OVER_BIT 5
`define SUPPLY_UNDER_BIT 4
`define BIAS_OVER_BIT 3
`define BIAS_UNDER_BIT 2
`define TXPOWER_OVER_BIT 1
`define TXPOWER_UNDER_BIT 0
`define NUM_CHANNELS 5
`define RX_CHANNEL 4

`endif

//--- logic/alarm_flag_pkg.sv
// Types shared by the diagnostic alarm flag bank
package alarm_flag_pkg;

  // One monitored quantity: result and thresholds, upper bytes only
  typedef struct packed {
    logic [7:0] result_msb;
    logic [7:0] max_threshold_msb;
    logic [7:0] min_threshold_msb;
  } chan_sample_t;

  // Channel order: temperature, supply, bias, tx power, rx power
  typedef chan_sample_t [4:0] conv_set_t;

  typedef enum logic {
    AWAIT_FIRST,
    MONITORING
  } bank_state_t;

endpackage

//--- logic/alarm_compare_unit.sv
// Threshold comparison for one monitored channel
`timescale 1ns/10ps
`default_nettype none

module alarm_compare_unit
  import alarm_flag_pkg::*;
(
  // Channel sample
  input wire chan_sample_t sample,
  // Comparison outcome
  output logic over_max,
  output logic under_min
);

  // Strict compares: equal to a threshold is within limits
  assign over_max = sample.result_msb > sample.max_threshold_msb;
  assign under_min = sample.result_msb < sample.min_threshold_msb;

endmodule // alarm_compare_unit

`default_nettype wire

//--- logic/diagnostic_alarm_flag_bank.sv
// Alarm flag registers updated from each conversion result
//
// Contract
// [RQ1] Both alarm registers zero until first conversion
// [RQ2] After first conversion flags follow the comparisons
// [RQ3] Temperature above max sets primary bit 7
// [RQ4] Temperature below min sets primary bit 6
// [RQ5] Supply above max sets primary bit 5
// [RQ6] Supply below min sets primary bit 4
// [RQ7] Bias above max sets primary bit 3
// [RQ8] Bias below min sets primary bit 2
// [RQ9] Tx power above max sets bit 1
// [RQ10] Tx power below min sets bit 0
// [RQ11] Rx power above max sets overload bit 7
// [RQ12] Rx power below min sets loss bit 6
// [RQ13] Flag one while condition present, else zero
// [RQ14] Host writes zero to reserved rx bits
// [RQ15] Read-only registers at 0x70, 0x71, address 0x51
// [RQ16] Every conversion re-evaluates every flag
// [RQ17] Reserved rx register bits always read zero
`timescale 1ns/10ps
`default_nettype none
`include "alarm_flag_consts.svh"

module diagnostic_alarm_flag_bank
  import alarm_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Conversion results and thresholds
  input wire logic conv_valid,
  input wire conv_set_t conv_data,
  // Register read port from the serial interface
  input wire logic rd_en,
  input wire logic [6:0] rd_dev_addr,
  input wire logic [7:0] rd_byte_addr,
  output logic rd_valid_reg,
  output logic rd_hit_reg,
  output logic [7:0] rd_data_reg,
  // Register write port from the serial interface
  input wire logic wr_en,
  input wire logic [6:0] wr_dev_addr,
  input wire logic [7:0] wr_byte_addr,
  input wire logic [7:0] wr_data,
  output logic wr_ignored_reg,
  output logic wr_reserved_err_reg,
  // Alarm state
  output logic [7:0] alarm_flags_primary_reg,
  output logic [7:0] alarm_flags_rx_power_reg,
  output logic first_conv_seen_reg
);

  // ==========================================================
  // Per-channel comparison
  // ==========================================================
  logic [`NUM_CHANNELS-1:0] over_w;
  logic [`NUM_CHANNELS-1:0] under_w;

  genvar c;
  generate
    for (c = 0; c < `NUM_CHANNELS; c = c + 1)
    begin : g_chan
      alarm_compare_unit u_cmp (
        .sample(conv_data[c]),
        .over_max(over_w[c]),
        .under_min(under_w[c])
      );
    end
  endgenerate

  // ==========================================================
  // Next flag values
  // ==========================================================
  logic [7:0] alarm_flags_primary_next;
  logic [7:0] alarm_flags_rx_power_next;

  always_comb
  begin
    alarm_flags_primary_next = `ALARM_RESET_VALUE;
    alarm_flags_primary_next[`TEMP_OVER_BIT] = over_w[0]; // [RQ3]
    alarm_flags_primary_next[`TEMP_UNDER_BIT] = under_w[0]; // [RQ4]
    alarm_flags_primary_next[`SUPPLY_OVER_BIT] = over_w[1]; // [RQ5]
    alarm_flags_primary_next[`SUPPLY_UNDER_BIT] = under_w[1]; // [RQ6]
    alarm_flags_primary_next[`BIAS_OVER_BIT] = over_w[2]; // [RQ7]
    alarm_flags_primary_next[`BIAS_UNDER_BIT] = under_w[2]; // [RQ8]
    alarm_flags_primary_next[`TXPOWER_OVER_BIT] = over_w[3]; // [RQ9]
    alarm_flags_primary_next[`TXPOWER_UNDER_BIT] = under_w[3]; // [RQ10]
  end

  always_comb
  begin
    // Reserved bits stay zero
    alarm_flags_rx_power_next = `ALARM_RESET_VALUE; // [RQ17]
    alarm_flags_rx_power_next[`RX_OVERLOAD_BIT] = over_w[`RX_CHANNEL]; // [RQ11]
    alarm_flags_rx_power_next[`RX_LOSS_BIT] = under_w[`RX_CHANNEL]; // [RQ12]
  end

  // ==========================================================
  // First-conversion tracking
  // ==========================================================
  bank_state_t state_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= AWAIT_FIRST;
    else
    begin
      case (state_reg)
        AWAIT_FIRST:
          if (conv_valid)
            state_reg <= MONITORING; // [RQ2]
        MONITORING:
          state_reg <= MONITORING;
        default:
          state_reg <= AWAIT_FIRST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      first_conv_seen_reg <= 1'b0;
    else
      first_conv_seen_reg <= (state_reg == MONITORING) || conv_valid;
  end

  // ==========================================================
  // Alarm flag registers
  // ==========================================================
  // Flags only move on a conversion, so they read zero until the first one
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_flags_primary_reg <= `ALARM_RESET_VALUE; // [RQ1]
      alarm_flags_rx_power_reg <= `ALARM_RESET_VALUE; // [RQ1]
    end
    else if (conv_valid)
    begin
      // Full overwrite: a cleared condition clears its flag
      alarm_flags_primary_reg <= alarm_flags_primary_next; // [RQ13] [RQ16]
      alarm_flags_rx_power_reg <= alarm_flags_rx_power_next; // [RQ13] [RQ16]
    end
  end

  // ==========================================================
  // Register read port
  // ==========================================================
  logic rd_dev_match;

  assign rd_dev_match = rd_dev_addr == `DIAG_DEV_ADDR;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
      rd_data_reg <= `ALARM_RESET_VALUE;
    end
    else
    begin
      rd_valid_reg <= rd_en;
      rd_hit_reg <= 1'b0;
      rd_data_reg <= `ALARM_RESET_VALUE;
      if (rd_en && rd_dev_match)
      begin
        case (rd_byte_addr)
          `ALARM_PRIMARY_OFFSET:
          begin
            rd_hit_reg <= 1'b1;
            rd_data_reg <= alarm_flags_primary_reg; // [RQ15]
          end
          `ALARM_RX_POWER_OFFSET:
          begin
            rd_hit_reg <= 1'b1;
            rd_data_reg <= alarm_flags_rx_power_reg; // [RQ15]
          end
          default:
          begin
            rd_hit_reg <= 1'b0;
            rd_data_reg <= `ALARM_RESET_VALUE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register write port
  // ==========================================================
  // Writes never change the flags; they are only reported
  logic wr_to_bank;

  assign wr_to_bank = wr_en && (wr_dev_addr == `DIAG_DEV_ADDR) &&
                      ((wr_byte_addr == `ALARM_PRIMARY_OFFSET) ||
                       (wr_byte_addr == `ALARM_RX_POWER_OFFSET));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_ignored_reg <= 1'b0;
    else
      wr_ignored_reg <= wr_to_bank; // [RQ15]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_reserved_err_reg <= 1'b0;
    else
      wr_reserved_err_reg <= wr_to_bank && (wr_byte_addr == `ALARM_RX_POWER_OFFSET) &&
                             ((wr_data & `ALARM_RX_RESERVED_MASK) != 8'h00); // [RQ14]
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  zero_before_first_a: assert property ( // [RQ1]
    (state_reg == AWAIT_FIRST) |->
      (alarm_flags_primary_reg == 8'h00) && (alarm_flags_rx_power_reg == 8'h00))
    else $error("Alarm flags nonzero before first conversion");

  first_conv_state_a: assert property ( // [RQ2]
    (state_reg == AWAIT_FIRST) && conv_valid |=>
      (state_reg == MONITORING) && first_conv_seen_reg)
    else $error("First conversion not recorded");

  generate
    for (c = 0; c < 4; c = c + 1)
    begin : g_chk
      chan_over_a: assert property ( // [RQ3] [RQ5] [RQ7] [RQ9]
        conv_valid && (conv_data[c].result_msb > conv_data[c].max_threshold_msb) |=>
          alarm_flags_primary_reg[7-2*c])
        else $error("Over-max alarm not set");
      chan_under_a: assert property ( // [RQ4] [RQ6] [RQ8] [RQ10]
        conv_valid && (conv_data[c].result_msb < conv_data[c].min_threshold_msb) |=>
          alarm_flags_primary_reg[6-2*c])
        else $error("Under-min alarm not set");
    end
  endgenerate

  rx_overload_a: assert property ( // [RQ11]
    conv_valid |=> alarm_flags_rx_power_reg[7] ==
      ($past(conv_data[4].result_msb) > $past(conv_data[4].max_threshold_msb)))
    else $error("Rx overload flag wrong");

  rx_loss_a: assert property ( // [RQ12]
    conv_valid |=> alarm_flags_rx_power_reg[6] ==
      ($past(conv_data[4].result_msb) < $past(conv_data[4].min_threshold_msb)))
    else $error("Rx loss flag wrong");

  in_limits_clear_a: assert property ( // [RQ13]
    conv_valid && (conv_data[0].result_msb <= conv_data[0].max_threshold_msb) &&
      (conv_data[0].result_msb >= conv_data[0].min_threshold_msb) |=>
      alarm_flags_primary_reg[7:6] == 2'b00)
    else $error("Flag set while within limits");

  hold_between_a: assert property ( // [RQ16]
    !conv_valid |=> $stable(alarm_flags_primary_reg) && $stable(alarm_flags_rx_power_reg))
    else $error("Flags moved without a conversion");

  reserved_zero_a: assert property ( // [RQ17]
    (alarm_flags_rx_power_reg & 8'h3F) == 8'h00)
    else $error("Reserved rx bits nonzero");

  read_primary_a: assert property ( // [RQ15]
    rd_en && (rd_dev_addr == 7'h51) && (rd_byte_addr == 8'h70) |=>
      rd_valid_reg && rd_hit_reg && (rd_data_reg == $past(alarm_flags_primary_reg)))
    else $error("Primary alarm read wrong");

  read_rx_a: assert property ( // [RQ15]
    rd_en && (rd_dev_addr == 7'h51) && (rd_byte_addr == 8'h71) |=>
      rd_valid_reg && rd_hit_reg && (rd_data_reg == $past(alarm_flags_rx_power_reg)))
    else $error("Rx alarm read wrong");

  write_ignored_a: assert property ( // [RQ15]
    wr_en && !conv_valid |=> (wr_ignored_reg == (($past(wr_dev_addr) == 7'h51) &&
      (($past(wr_byte_addr) == 8'h70) || ($past(wr_byte_addr) == 8'h71)))) &&
      $stable(alarm_flags_primary_reg) && $stable(alarm_flags_rx_power_reg))
    else $error("Write altered alarm flags");

  first_conv_c: cover property (
    (state_reg == AWAIT_FIRST) ##1 conv_valid ##1 (alarm_flags_primary_reg != 8'h00));
  flag_clears_c: cover property (
    alarm_flags_rx_power_reg[6] ##[1:20] !alarm_flags_rx_power_reg[6]);
  read_hit_c: cover property (rd_valid_reg && rd_hit_reg && (rd_data_reg != 8'h00));

endmodule // diagnostic_alarm_flag_bank

`default_nettype wire

//--- tb/host_model.sv
// Host model issuing single-byte register reads and writes
`timescale 1ns/10ps
`default_nettype none

module host_model
(
  // Clock
  input wire logic ref_clk,
  // Read port
  output logic rd_en,
  output logic [6:0] rd_dev_addr,
  output logic [7:0] rd_byte_addr,
  input wire logic rd_valid_reg,
  input wire logic rd_hit_reg,
  input wire logic [7:0] rd_data_reg,
  // Write port
  output logic wr_en,
  output logic [6:0] wr_dev_addr,
  output logic [7:0] wr_byte_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ignored_reg,
  input wire logic wr_reserved_err_reg
);
  initial
  begin
    {rd_en, rd_dev_addr, rd_byte_addr} = '0;
    {wr_en, wr_dev_addr, wr_byte_addr, wr_data} = '0;
  end

  // Answer is registered on the taking edge and sampled 1 ns after it
  task automatic rd(input logic [6:0] dev, input logic [7:0] adr, output logic ok, output logic hit,
    output logic [7:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    rd_dev_addr <= dev;
    rd_byte_addr <= adr;
    @(posedge ref_clk);
    // Released lines show inverted values
    rd_en <= 1'b0;
    rd_dev_addr <= ~dev;
    rd_byte_addr <= ~adr;
    #1;
    ok = rd_valid_reg;
    hit = rd_hit_reg;
    d = rd_data_reg;
  endtask

  // Reserved bits sent as zero unless told to misbehave
  task automatic wr(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] d, input bit bad,
    output logic ign, output logic err);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_dev_addr <= dev;
    wr_byte_addr <= adr;
    wr_data <= (adr == 8'h71 && !bad) ? (d & 8'hC0) : d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wr_dev_addr <= ~dev;
    wr_byte_addr <= ~adr;
    wr_data <= ~d;
    #1;
    ign = wr_ignored_reg;
    err = wr_reserved_err_reg;
  endtask
endmodule // host_model

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the diagnostic alarm flag bank
`timescale 1ns/10ps
`default_nettype none
`include "alarm_flag_consts.svh"

module testbench
  import alarm_flag_pkg::*;
;
  logic ref_clk, rst_n, conv_valid, rd_en, wr_en, rd_valid_reg, rd_hit_reg;
  logic wr_ignored_reg, wr_reserved_err_reg, first_conv_seen_reg, ok, hit, ign, err;
  logic [6:0] rd_dev_addr, wr_dev_addr;
  logic [7:0] rd_byte_addr, wr_byte_addr, wr_data, rd_data_reg, d;
  logic [7:0] alarm_flags_primary_reg, alarm_flags_rx_power_reg;
  logic [15:0] e;
  conv_set_t conv_data, cs, c2;
  int error_cnt, n_compared, seed;

  diagnostic_alarm_flag_bank i_diagnostic_alarm_flag_bank (.ref_clk, .rst_n, .conv_valid, .conv_data,
    .rd_en, .rd_dev_addr, .rd_byte_addr, .rd_valid_reg, .rd_hit_reg, .rd_data_reg, .wr_en, .wr_dev_addr,
    .wr_byte_addr, .wr_data, .wr_ignored_reg, .wr_reserved_err_reg, .alarm_flags_primary_reg,
    .alarm_flags_rx_power_reg, .first_conv_seen_reg);
  host_model i_host_model (.ref_clk, .rd_en, .rd_dev_addr, .rd_byte_addr, .rd_valid_reg, .rd_hit_reg,
    .rd_data_reg, .wr_en, .wr_dev_addr, .wr_byte_addr, .wr_data, .wr_ignored_reg, .wr_reserved_err_reg);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Reference model and checks
  function automatic logic [15:0] ref_flags(input conv_set_t c);
    logic [15:0] f;
    f = '0;
    for (int i = 0; i < 5; i++)
    begin
      f[15-2*i] = int'(c[i].result_msb) > int'(c[i].max_threshold_msb);
      f[14-2*i] = int'(c[i].result_msb) < int'(c[i].min_threshold_msb);
    end
    return f;
  endfunction

  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    n_compared++;
    if (g !== ex)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic chk_all(input logic [15:0] ex);
    chk("primary", ex[15:8], alarm_flags_primary_reg);
    chk("rx_power", ex[7:0], alarm_flags_rx_power_reg);
    i_host_model.rd(`DIAG_DEV_ADDR, `ALARM_PRIMARY_OFFSET, ok, hit, d);
    chk("rd_primary", ex[15:8], d);
    chk("rd_hit", 8'h03, {6'h00, ok, hit});
    i_host_model.rd(`DIAG_DEV_ADDR, `ALARM_RX_POWER_OFFSET, ok, hit, d);
    chk("rd_rx_power", ex[7:0], d);
    chk("rd_hit_rx", 8'h03, {6'h00, ok, hit});
  endtask

  task automatic gen(output conv_set_t c);
    int k;
    for (int i = 0; i < 5; i++)
    begin
      c[i].max_threshold_msb = 8'($random(seed));
      c[i].min_threshold_msb = 8'($random(seed));
      k = $unsigned($random(seed)) % 6;
      c[i].result_msb = k == 0 ? c[i].max_threshold_msb : k == 1 ? c[i].max_threshold_msb + 8'h01
        : k == 2 ? c[i].min_threshold_msb : k == 3 ? c[i].min_threshold_msb - 8'h01 : 8'($random(seed));
    end
  endtask

  task automatic conv(input conv_set_t c);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_data <= c;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    conv_data <= ~c;
    #1;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    {rst_n, conv_valid, conv_data} = '0;
    error_cnt = 0;
    n_compared = 0;
    seed = 36;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_all('0);
    chk("seen", 8'h00, {7'h00, first_conv_seen_reg});
    for (int j = 0; j < 3; j++)
    begin
      i_host_model.rd(j == 0 ? 7'h50 : `DIAG_DEV_ADDR, j == 1 ? 8'h72 : j == 2 ? 8'h6F : 8'h70, ok, hit, d);
      chk("miss_hit", 8'h02, {6'h00, ok, hit});
      chk("miss_data", 8'h00, d);
    end
    for (int j = 0; j < 40; j++)
    begin
      gen(cs);
      conv(cs);
      chk_all(ref_flags(cs));
    end
    chk("seen", 8'h01, {7'h00, first_conv_seen_reg});
    // Writes never alter flags
    for (int j = 0; j < 4; j++)
    begin
      i_host_model.wr(j == 3 ? 7'h50 : `DIAG_DEV_ADDR, j == 0 ? 8'h70 : 8'h71, 8'hFF, j == 2, ign, err);
      chk("wr_status", j == 3 ? 8'h00 : j == 2 ? 8'h03 : 8'h02, {6'h00, ign, err});
    end
    chk_all(ref_flags(cs));
    // Back-to-back conversions
    gen(cs);
    gen(c2);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_data <= cs;
    @(posedge ref_clk);
    conv_data <= c2;
    #1;
    e = ref_flags(cs);
    chk("b2b_first", e[15:8], alarm_flags_primary_reg);
    chk("b2b_first_rx", e[7:0], alarm_flags_rx_power_reg);
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    #1;
    chk_all(ref_flags(c2));
    // Reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1;
    chk("rst_primary", 8'h00, alarm_flags_primary_reg);
    chk("rst_rx_power", 8'h00, alarm_flags_rx_power_reg);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_all('0);
    chk("seen_after_rst", 8'h00, {7'h00, first_conv_seen_reg});
    end_sim();
  end

  initial
  begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule // testbench

`default_nettype wire
